// *** rtca_asserts.sv ***
`timescale 1ns/1ps
`include "rtca_consts.vh"
module rtca_asserts (
	input wire i_clk,
	input wire i_rstn,
	input wire o_alarm_or_clock_out_pin_o,
	input wire [1:0] o_s_axi_bresp,
	input wire o_s_axi_bvalid,
	input wire i_s_axi_bready,
	input wire [7:0] i_s_axi_araddr,
	input wire i_s_axi_arvalid,
	input wire o_s_axi_arready,
	input wire [31:0] o_s_axi_rdata,
	input wire [1:0] o_s_axi_rresp,
	input wire o_s_axi_rvalid,
	input wire i_s_axi_rready
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	a_pin_drain_only: assert property (o_alarm_or_clock_out_pin_o == 1'b0)
		else $error("pin data not low");
	a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
		else $error("no read answer");
	a_read_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
		o_s_axi_rvalid && $stable(o_s_axi_rdata))
		else $error("read answer dropped");
	a_read_done: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid)
		else $error("read answer stuck");
	a_read_refused: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
		else $error("address taken while busy");
	a_write_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
		o_s_axi_bvalid && $stable(o_s_axi_bresp))
		else $error("write answer dropped");
	a_write_done: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
		else $error("write answer stuck");
	a_unmapped_err: assert property (i_s_axi_arvalid && o_s_axi_arready &&
		i_s_axi_araddr == 8'h3C |=> o_s_axi_rresp == `RTCA_RESP_ERR && o_s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
endmodule // rtca_asserts
bind rtca_core rtca_asserts u_rtca_asserts (.i_clk(i_clk), .i_rstn(i_rstn),
	.o_alarm_or_clock_out_pin_o(o_alarm_or_clock_out_pin_o), .o_s_axi_bresp(o_s_axi_bresp),
	.o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
	.i_s_axi_araddr(i_s_axi_araddr), .i_s_axi_arvalid(i_s_axi_arvalid),
	.o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
	.o_s_axi_rresp(o_s_axi_rresp), .o_s_axi_rvalid(o_s_axi_rvalid),
	.i_s_axi_rready(i_s_axi_rready));

// *** rtca_consts.vh ***
`ifndef RTCA_CONSTS_VH
`define RTCA_CONSTS_VH

// Register byte offsets.
`define RTCA_A_SEC 8'h00
`define RTCA_A_MIN 8'h04
`define RTCA_A_HOUR 8'h08
`define RTCA_A_DATE 8'h0C
`define RTCA_A_MON 8'h10
`define RTCA_A_YEAR 8'h14
`define RTCA_A_WDAY 8'h18
`define RTCA_A_AL0 8'h20
`define RTCA_A_CTRL 8'h40
`define RTCA_A_STAT 8'h44
`define RTCA_A_ISTAT 8'h48
`define RTCA_A_IMASK 8'h4C

// Field positions.
`define RTCA_C_ALARM_ENABLE_BIT 0
`define RTCA_C_PULSE 1
`define RTCA_C_ACLR 2
`define RTCA_C_DIVIDED_CLOCK_OUTPUT 4
`define RTCA_AL_EN 7
`define RTCA_I_ALARM 0
`define RTCA_I_SEC 1

// Reset values.
`define RTCA_RST_TIME 8'h00
`define RTCA_RST_DAY 8'h01
`define RTCA_RST_CTRL 8'h00

// Bus answers.
`define RTCA_RESP_OK 2'h0
`define RTCA_RESP_ERR 2'h2

// Timing.
`define RTCA_XTAL_HZ 32768
`define RTCA_PULSE_MS 250
`define RTCA_PULSE_TICKS (`RTCA_XTAL_HZ * `RTCA_PULSE_MS / 1000)

`endif

// *** rtca_core.v ***
// Notes on behaviour
// - Calendar runs 2000 to 2099; February gets day 29 in leap years.
// - Seconds, minutes, hours, date, month, year, weekday: own counters, host access.
// - Alarm fires when every enabled alarm field equals the running time.
// - Each alarm sets the alarm hit flag in the status register.
// - With alarm enabled, each alarm also pulls the shared pin low.
// - Matches repeat naturally, so a repeating alarm fires every time they recur.
// - Frequency select field picks interrupt or clock output on the pin.
// - Interrupt function drives the pin open-drain, active low.
// - Clock function drives a crystal-derived open-drain clock at selected rate.
// - Timebase counts edges of a 32.768kHz crystal or external clock.
// - Single-event mode: pin low and flag set on a match.
// - Pulsed mode: pin low for 250ms and flag set on each match.
// - Clock output enabled disables the alarm entirely.
// - Host write of 1 to bit 0 clears the flag; auto-clear option clears it on read.
`timescale 1ns/1ps
`include "rtca_consts.vh"

module rtca_core #(
	parameter XTAL_HZ = `RTCA_XTAL_HZ,
	parameter PULSE_TICKS = `RTCA_PULSE_TICKS
) (
	// Clock and reset.
	input wire i_clk,
	input wire i_rstn,
	// Crystal timebase.
	input wire i_crystal_input,
	// Shared open-drain pin.
	output wire o_alarm_or_clock_out_pin_o,
	output reg o_alarm_or_clock_out_pin_oe,
	// Interrupt.
	output reg o_irq,
	// AXI4-Lite write.
	input wire [7:0] i_s_axi_awaddr,
	input wire i_s_axi_awvalid,
	output wire o_s_axi_awready,
	input wire [31:0] i_s_axi_wdata,
	input wire [3:0] i_s_axi_wstrb,
	input wire i_s_axi_wvalid,
	output wire o_s_axi_wready,
	output reg [1:0] o_s_axi_bresp,
	output reg o_s_axi_bvalid,
	input wire i_s_axi_bready,
	// AXI4-Lite read.
	input wire [7:0] i_s_axi_araddr,
	input wire i_s_axi_arvalid,
	output wire o_s_axi_arready,
	output reg [31:0] o_s_axi_rdata,
	output reg [1:0] o_s_axi_rresp,
	output reg o_s_axi_rvalid,
	input wire i_s_axi_rready
);

	function [7:0] days_in_month;
		input [7:0] m;
		input [7:0] y;
		begin
			case (m)
				8'h02: days_in_month = (y[1:0] == 2'h0) ? 8'h1D : 8'h1C;
				8'h04, 8'h06, 8'h09, 8'h0B: days_in_month = 8'h1E;
				default: days_in_month = 8'h1F;
			endcase
		end
	endfunction

	function mapped;
		input [7:0] a;
		begin
			mapped = (a[1:0] == 2'h0) &&
				((a <= `RTCA_A_WDAY) ||
				(a >= `RTCA_A_AL0 && a < `RTCA_A_AL0 + 8'h18) ||
				(a >= `RTCA_A_CTRL && a <= `RTCA_A_IMASK));
		end
	endfunction

	// Crystal sampling: three flops, a new level counts once the last two agree.
	reg [2:0] xs_q;
	reg xlvl_q;
	wire xedge = (xs_q[1] == xs_q[2]) && (xs_q[2] != xlvl_q) && xs_q[2];

	// Bus state.
	reg aw_full_q;
	reg w_full_q;
	reg [7:0] wa_q;
	reg [7:0] wd_q;
	reg ws_q;
	wire wr_go = aw_full_q & w_full_q & ~o_s_axi_bvalid;
	wire wr_ok = wr_go & ws_q & mapped(wa_q);
	wire rd_go = i_s_axi_arvalid & ~o_s_axi_rvalid;

	// Time and control state.
	reg [7:0] sec_q, min_q, hour_q, date_q, mon_q, year_q, wday_q;
	reg [7:0] al_q [0:5];
	reg [7:0] ctrl_q;
	reg [15:0] div_q;
	reg [14:0] fdiv_q;
	reg [15:0] pul_q;
	reg tick_q;
	reg flag_q;
	reg [1:0] istat_q;
	reg [1:0] imask_q;
	reg [7:0] rd_d;

	wire [3:0] fsel = ctrl_q[`RTCA_C_DIVIDED_CLOCK_OUTPUT+3:`RTCA_C_DIVIDED_CLOCK_OUTPUT];
	wire divided_clock_output_on = (fsel != 4'h0);
	wire alarm_enable_bit = ctrl_q[`RTCA_C_ALARM_ENABLE_BIT] & ~divided_clock_output_on;
	wire tick = xedge && (div_q == XTAL_HZ[15:0] - 16'h0001);

	// Calendar advance.
	reg [7:0] t_sec, t_min, t_hour, t_date, t_mon, t_year, t_wday;
	always @* begin
		t_sec = sec_q;
		t_min = min_q;
		t_hour = hour_q;
		t_date = date_q;
		t_mon = mon_q;
		t_year = year_q;
		t_wday = wday_q;
		if (tick) begin
			if (sec_q >= 8'h3B) begin
				t_sec = 8'h00;
				if (min_q >= 8'h3B) begin
					t_min = 8'h00;
					if (hour_q >= 8'h17) begin
						t_hour = 8'h00;
						t_wday = (wday_q >= 8'h06) ? 8'h00 : wday_q + 8'h01;
						if (date_q >= days_in_month(mon_q, year_q)) begin
							t_date = 8'h01;
							if (mon_q >= 8'h0C) begin
								t_mon = 8'h01;
								t_year = (year_q >= 8'h63) ? 8'h00 : year_q + 8'h01;
							end else begin
								t_mon = mon_q + 8'h01;
							end
						end else begin
							t_date = date_q + 8'h01;
						end
					end else begin
						t_hour = hour_q + 8'h01;
					end
				end else begin
					t_min = min_q + 8'h01;
				end
			end else begin
				t_sec = sec_q + 8'h01;
			end
		end
	end

	// Alarm compare, the cycle after a rollover.
	wire [47:0] cur = {wday_q, mon_q, date_q, hour_q, min_q, sec_q};
	reg match;
	reg any_en;
	integer k;
	always @* begin
		match = 1'b1;
		any_en = 1'b0;
		for (k = 0; k < 6; k = k + 1) begin
			if (al_q[k][`RTCA_AL_EN]) begin
				any_en = 1'b1;
				if (al_q[k][6:0] != cur[8*k +: 7]) begin
					match = 1'b0;
				end
			end
		end
	end
	wire alarm_ev = tick_q & alarm_enable_bit & any_en & match;

	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			xs_q <= 3'h0;
			xlvl_q <= 1'b0;
			div_q <= 16'h0000;
			fdiv_q <= 15'h0000;
			tick_q <= 1'b0;
		end else begin
			xs_q <= {xs_q[1:0], i_crystal_input};
			if (xs_q[1] == xs_q[2]) begin
				xlvl_q <= xs_q[2];
			end
			if (wr_ok && wa_q == `RTCA_A_SEC) begin
				div_q <= 16'h0000;
			end else if (tick) begin
				div_q <= 16'h0000;
			end else if (xedge) begin
				div_q <= div_q + 16'h0001;
			end
			if (xedge) begin
				fdiv_q <= fdiv_q + 15'h0001;
			end
			tick_q <= tick;
		end
	end

	// Time registers: a host write wins over the count in the same cycle.
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sec_q <= `RTCA_RST_TIME;
			min_q <= `RTCA_RST_TIME;
			hour_q <= `RTCA_RST_TIME;
			date_q <= `RTCA_RST_DAY;
			mon_q <= `RTCA_RST_DAY;
			year_q <= `RTCA_RST_TIME;
			wday_q <= `RTCA_RST_TIME;
		end else begin
			sec_q <= (wr_ok && wa_q == `RTCA_A_SEC) ? wd_q : t_sec;
			min_q <= (wr_ok && wa_q == `RTCA_A_MIN) ? wd_q : t_min;
			hour_q <= (wr_ok && wa_q == `RTCA_A_HOUR) ? wd_q : t_hour;
			date_q <= (wr_ok && wa_q == `RTCA_A_DATE) ? wd_q : t_date;
			mon_q <= (wr_ok && wa_q == `RTCA_A_MON) ? wd_q : t_mon;
			year_q <= (wr_ok && wa_q == `RTCA_A_YEAR) ? wd_q : t_year;
			wday_q <= (wr_ok && wa_q == `RTCA_A_WDAY) ? wd_q : t_wday;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_al
			wire [31:0] al_addr = `RTCA_A_AL0 + 32'h00000004 * g;
			always @(posedge i_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					al_q[g] <= `RTCA_RST_TIME;
				end else if (wr_ok && wa_q == al_addr[7:0]) begin
					al_q[g] <= wd_q;
				end
			end
		end
	endgenerate

	// Control, flag, pulse timer, interrupt status.
	wire rd_stat = rd_go && i_s_axi_araddr == `RTCA_A_STAT;
	wire rd_istat = rd_go && i_s_axi_araddr == `RTCA_A_ISTAT;
	wire [1:0] iev = {tick, alarm_ev};
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ctrl_q <= `RTCA_RST_CTRL;
			flag_q <= 1'b0;
			pul_q <= 16'h0000;
			istat_q <= 2'h0;
			imask_q <= 2'h0;
			o_irq <= 1'b0;
		end else begin
			if (wr_ok && wa_q == `RTCA_A_CTRL) begin
				ctrl_q <= wd_q;
			end
			if (wr_ok && wa_q == `RTCA_A_IMASK) begin
				imask_q <= wd_q[1:0];
			end
			if (alarm_ev) begin
				flag_q <= 1'b1;
			end else if (wr_ok && wa_q == `RTCA_A_STAT && wd_q[0]) begin
				flag_q <= 1'b0;
			end else if (rd_stat && ctrl_q[`RTCA_C_ACLR]) begin
				flag_q <= 1'b0;
			end
			if (alarm_ev && ctrl_q[`RTCA_C_PULSE]) begin
				pul_q <= PULSE_TICKS[15:0];
			end else if (!alarm_enable_bit) begin
				pul_q <= 16'h0000;
			end else if (xedge && pul_q != 16'h0000) begin
				pul_q <= pul_q - 16'h0001;
			end
			istat_q <= iev | (rd_istat ? 2'h0 : istat_q);
			o_irq <= |(istat_q & imask_q);
		end
	end

	// Shared pin: enable high pulls the line low.
	wire divided_clock_output_lvl = (fsel == 4'h1) ? xlvl_q : fdiv_q[fsel - 4'h2];
	wire irq_low = ctrl_q[`RTCA_C_PULSE] ? (pul_q != 16'h0000) : flag_q;
	assign o_alarm_or_clock_out_pin_o = 1'b0;
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_alarm_or_clock_out_pin_oe <= 1'b0;
		end else if (divided_clock_output_on) begin
			o_alarm_or_clock_out_pin_oe <= ~divided_clock_output_lvl;
		end else begin
			o_alarm_or_clock_out_pin_oe <= alarm_enable_bit & irq_low;
		end
	end

	// Read data.
	always @* begin
		case (i_s_axi_araddr)
			`RTCA_A_SEC: rd_d = sec_q;
			`RTCA_A_MIN: rd_d = min_q;
			`RTCA_A_HOUR: rd_d = hour_q;
			`RTCA_A_DATE: rd_d = date_q;
			`RTCA_A_MON: rd_d = mon_q;
			`RTCA_A_YEAR: rd_d = year_q;
			`RTCA_A_WDAY: rd_d = wday_q;
			`RTCA_A_CTRL: rd_d = ctrl_q;
			`RTCA_A_STAT: rd_d = {7'h00, flag_q};
			`RTCA_A_ISTAT: rd_d = {6'h00, istat_q};
			`RTCA_A_IMASK: rd_d = {6'h00, imask_q};
			default: begin
				if (mapped(i_s_axi_araddr)) begin
					rd_d = al_q[i_s_axi_araddr[4:2]];
				end else begin
					rd_d = 8'h00;
				end
			end
		endcase
	end

	// AXI4-Lite slave.
	assign o_s_axi_awready = ~aw_full_q;
	assign o_s_axi_wready = ~w_full_q;
	assign o_s_axi_arready = ~o_s_axi_rvalid;
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			wa_q <= 8'h00;
			wd_q <= 8'h00;
			ws_q <= 1'b0;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= `RTCA_RESP_OK;
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= 32'h00000000;
			o_s_axi_rresp <= `RTCA_RESP_OK;
		end else begin
			if (i_s_axi_awvalid && !aw_full_q) begin
				aw_full_q <= 1'b1;
				wa_q <= i_s_axi_awaddr;
			end else if (wr_go) begin
				aw_full_q <= 1'b0;
			end
			if (i_s_axi_wvalid && !w_full_q) begin
				w_full_q <= 1'b1;
				wd_q <= i_s_axi_wdata[7:0];
				ws_q <= i_s_axi_wstrb[0];
			end else if (wr_go) begin
				w_full_q <= 1'b0;
			end
			if (wr_go) begin
				o_s_axi_bvalid <= 1'b1;
				o_s_axi_bresp <= mapped(wa_q) ? `RTCA_RESP_OK : `RTCA_RESP_ERR;
			end else if (i_s_axi_bready) begin
				o_s_axi_bvalid <= 1'b0;
			end
			if (rd_go) begin
				o_s_axi_rvalid <= 1'b1;
				o_s_axi_rdata <= {24'h000000, rd_d};
				o_s_axi_rresp <= mapped(i_s_axi_araddr) ? `RTCA_RESP_OK : `RTCA_RESP_ERR;
			end else if (i_s_axi_rready) begin
				o_s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // rtca_core

// *** rtca_core_tb.sv ***
`timescale 1ns/1ps
`include "rtca_consts.vh"
module rtca_core_tb;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic xtal, awready, wready, bvalid, arready, rvalid, pin_o, oe, irq;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic oe_q = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	int fails = 0, check_count = 0, rises = 0, r0, hi_len = 0, h0;

	always #2.5 i_clk = ~i_clk;
	rtca_xtal_model u_rtca_xtal_model (.o_xtal(xtal));
	// An 8 Hz crystal keeps runs short; 250 ms of it is two crystal edges.
	rtca_core #(.XTAL_HZ(8), .PULSE_TICKS(2)) u_rtca_core (.i_clk(i_clk), .i_rstn(i_rstn),
		.i_crystal_input(xtal), .o_alarm_or_clock_out_pin_o(pin_o),
		.o_alarm_or_clock_out_pin_oe(oe), .o_irq(irq), .i_s_axi_awaddr(awaddr),
		.i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
		.i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
		.o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
		.i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
		.o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
		.i_s_axi_rready(rready));

	always @(posedge i_clk) begin
		oe_q <= oe;
		if (oe && !oe_q)
			rises <= rises + 1;
		if (oe)
			hi_len <= hi_len + 1;
	end

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask

	// Ends mid-cycle, so that a check after it sees settled outputs.
	task idle(input int n);
		repeat (n) @(posedge i_clk);
		@(negedge i_clk);
	endtask

	// Handshakes are judged mid-cycle, where the design's outputs are settled.
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic ta, tw, tb;
		tb = 1'b0;
		@(posedge i_clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!tb) begin
			@(negedge i_clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			if (tb)
				chk("bresp", {30'h0, `RTCA_RESP_OK}, {30'h0, bresp});
			@(posedge i_clk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ta, tr;
		tr = 1'b0;
		@(posedge i_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!tr) begin
			@(negedge i_clk);
			ta = arvalid && arready;
			tr = rvalid;
			if (tr) begin
				chk("rdata", e, rdata);
				chk("rresp", {30'h0, er}, {30'h0, rresp});
			end
			@(posedge i_clk);
			if (ta)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask

	task end_sim;
		$display("checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		#50000;
		fails++;
		end_sim();
	end

	initial begin
		repeat (5) @(posedge i_clk);
		i_rstn <= 1'b1;
		rd(`RTCA_A_DATE, 32'h1, `RTCA_RESP_OK);
		rd(8'h3C, 32'h0, `RTCA_RESP_ERR);
		wr(`RTCA_A_YEAR, 8'h04);
		wr(`RTCA_A_MON, 8'h02);
		wr(`RTCA_A_DATE, 8'h1C);
		wr(`RTCA_A_HOUR, 8'h17);
		wr(`RTCA_A_MIN, 8'h3B);
		wr(`RTCA_A_SEC, 8'h3B);
		idle(180);
		rd(`RTCA_A_DATE, 32'h1D, `RTCA_RESP_OK);
		rd(`RTCA_A_MON, 32'h2, `RTCA_RESP_OK);
		rd(`RTCA_A_HOUR, 32'h0, `RTCA_RESP_OK);
		// Alarm on second 5 only, single event mode.
		wr(`RTCA_A_AL0, 8'h85);
		wr(`RTCA_A_IMASK, 8'h01);
		wr(`RTCA_A_CTRL, 8'h01);
		wr(`RTCA_A_SEC, 8'h04);
		idle(200);
		chk("irq", 32'h1, {31'h0, irq});
		chk("pin_oe", 32'h1, {31'h0, oe});
		rd(`RTCA_A_STAT, 32'h1, `RTCA_RESP_OK);
		rd(`RTCA_A_ISTAT, 32'h3, `RTCA_RESP_OK);
		idle(3);
		chk("irq", 32'h0, {31'h0, irq});
		wr(`RTCA_A_STAT, 8'h01);
		idle(3);
		chk("pin_oe", 32'h0, {31'h0, oe});
		// Pulsed mode: one pulse of 250 ms, two crystal periods or 32 clocks, flag set again.
		// The load lags the second tick by one clock, so 31 clocks are seen.
		wr(`RTCA_A_CTRL, 8'h03);
		r0 = rises;
		h0 = hi_len;
		wr(`RTCA_A_SEC, 8'h04);
		idle(260);
		chk("pulse_count", 32'h1, rises - r0);
		chk("pulse_len", 32'h1, {31'h0, (hi_len - h0 >= 31) && (hi_len - h0 <= 32)});
		chk("pin_oe", 32'h0, {31'h0, oe});
		rd(`RTCA_A_STAT, 32'h1, `RTCA_RESP_OK);
		wr(`RTCA_A_CTRL, 8'h05);
		rd(`RTCA_A_STAT, 32'h1, `RTCA_RESP_OK);
		rd(`RTCA_A_STAT, 32'h0, `RTCA_RESP_OK);
		// Raw crystal rate on the pin; the alarm must stay silent.
		// The mode switch itself may raise the pin once; let it pass before counting.
		wr(`RTCA_A_CTRL, 8'h11);
		idle(2);
		r0 = rises;
		wr(`RTCA_A_SEC, 8'h04);
		idle(200);
		chk("clock_out", 32'h1, {31'h0, (rises - r0 >= 11) && (rises - r0 <= 13)});
		rd(`RTCA_A_STAT, 32'h0, `RTCA_RESP_OK);
		// Crystal halved: one rise every two crystal periods, six in 192 clocks.
		wr(`RTCA_A_CTRL, 8'h21);
		idle(2);
		r0 = rises;
		idle(192);
		chk("clock_half", 32'h1, {31'h0, (rises - r0 >= 5) && (rises - r0 <= 7)});
		end_sim();
	end
endmodule // rtca_core_tb

// *** rtca_xtal_model.sv ***
`timescale 1ns/1ps
module rtca_xtal_model #(
	parameter int HALF_NS = 40
) (
	output logic o_xtal
);
	// Free running source, as a crystal or external clock would be.
	initial o_xtal = 1'b0;
	always #(HALF_NS) o_xtal = ~o_xtal;
endmodule // rtca_xtal_model
